//--- rtl/smbbt_map.svh
// Register offsets, field positions, reset values and timing counts for the byte transfer block
`ifndef SMBBT_MAP_SVH
`define SMBBT_MAP_SVH
`define SMBBT_DATA_ADDR      8'hC2
`define SMBBT_CTRL_ADDR      8'hC0
`define SMBBT_DATA_RESET     8'h00
`define SMBBT_BIT_SI         0
`define SMBBT_BIT_ACK        1
`define SMBBT_BIT_ARBITRATION_LOST_FLAG    2
`define SMBBT_BIT_ACK_RESPONSE_NEEDED      3
`define SMBBT_BIT_STO        4
`define SMBBT_BIT_STA        5
`define SMBBT_BIT_TXMODE     6
`define SMBBT_BIT_MASTER     7
`define SMBBT_HALF_BIT_NS    5000
`define SMBBT_CLK_NS         25
`define SMBBT_HALF_BIT_CYC   (`SMBBT_HALF_BIT_NS / `SMBBT_CLK_NS)
`endif

//--- rtl/smbbt_pkg.sv
// Types shared by the byte transfer block
package smbbt_pkg;
  typedef enum logic [3:0] {
    SMBBT_SLV_RX = 4'h1,
    SMBBT_SLV_TX = 4'h2,
    SMBBT_MST_RX = 4'h4,
    SMBBT_MST_TX = 4'h8
  } smbbt_mode_type;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smbbt_sfr_req_type;
  typedef struct packed {
    logic scl;
    logic sda;
  } smbbt_line_type;
endpackage

//--- rtl/smbbt_sync.sv
// Two-flop synchroniser with edge detection for the bus lines
`timescale 1ns/1ps
module smbbt_sync
  import smbbt_pkg::*;
(
  input  wire logic           clk,
  input  wire logic           nrst,
  input  wire smbbt_line_type pin_in,
  output smbbt_line_type      line,
  output logic                scl_rise,
  output logic                scl_fall,
  output logic                start_seen,
  output logic                stop_seen
);
  smbbt_line_type meta;
  smbbt_line_type prev;
  // First stage feeds only the second stage
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta <= '{scl: 1'b1, sda: 1'b1};
      line <= '{scl: 1'b1, sda: 1'b1};
      prev <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      meta <= pin_in;
      line <= meta;
      prev <= line;
    end
  end
  // Edges and bus conditions from settled levels only
  assign scl_rise   = line.scl & ~prev.scl;
  assign scl_fall   = ~line.scl & prev.scl;
  assign start_seen = line.scl & prev.scl & prev.sda & ~line.sda;
  assign stop_seen  = line.scl & prev.scl & ~prev.sda & line.sda;
endmodule

//--- rtl/smbbt_shift.sv
// Shared 8-bit data register: parallel access by software, serial in and out on the bus
`timescale 1ns/1ps
`include "smbbt_map.svh"
module smbbt_shift
  import smbbt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       shift,
  input  wire logic       sda_in,
  output logic [7:0]      data
);
  // One register for both directions; the top bit is the next bit on the line
  always_ff @(posedge clk)
  begin
    if (!nrst)
      data <= `SMBBT_DATA_RESET;
    else if (load)
      data <= load_data;
    else if (shift)
      data <= {data[6:0], sda_in};
  end
endmodule

//--- rtl/smbbt_core.sv
// Byte transfer and mode sequencing of the two-wire serial interface
`timescale 1ns/1ps
`include "smbbt_map.svh"
// How it works
// - Data register is accessible and frozen while the byte event flag is set.
// - Transmitted bytes leave the data register most significant bit first.
// - First received bit lands in the most significant bit.
// - Line level shifts back in while transmitting; register holds last bus byte.
// - Lost arbitration turns master transmitter into slave receiver, byte kept.
// - Exactly one of four modes; master from START until STOP or arbitration loss.
// - Interrupt before acknowledge when receiving, after it when transmitting.
// - Master transmit: drive clock, START, address with write bit, data bytes.
// - Master transmit ends with STOP once stop request is set.
// - No data write after master transmit event means master receive next.
// - Master receive: START, address with read bit, keep clocking slave data.
// - Each master-received byte sets ack needed; software writes ACK one or NACK zero.
// - Master receive ends on generated STOP; data write switches to master transmit.
// - With inhibit clear, address with write bit enters slave receive and interrupts.
// - NACKed slave address mutes slave events until next START.
// - Slave receive: software acknowledges bytes; STOP exits; data write means slave transmit.
// - Read-addressed slave interrupts with ack needed; then sends loaded bytes.
// - No data write after slave transmit event falls back to slave receive; STOP exits.
// - Clock line held low while the byte event flag stays set.
// - Ack needed flag clears after every acknowledge cycle.
module smbbt_core
  import smbbt_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = 7'h2A
)
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire smbbt_sfr_req_type sfr_req,
  output logic [7:0]             sfr_rdata,
  input  wire logic              enable,
  input  wire logic              slave_inhibit,
  input  wire smbbt_line_type    pin_in,
  output logic                   scl_out,
  output logic                   scl_oe,
  output logic                   sda_out,
  output logic                   sda_oe
);
  localparam logic [7:0] HALF_CYC = 8'(`SMBBT_HALF_BIT_CYC);

  typedef enum logic [6:0] {
    SMBBT_IDLE  = 7'h01,
    SMBBT_START = 7'h02,
    SMBBT_BITS  = 7'h04,
    SMBBT_ACK   = 7'h08,
    SMBBT_HOLD  = 7'h10,
    SMBBT_STOP  = 7'h20,
    SMBBT_MUTE  = 7'h40
  } smbbt_state_type;

  smbbt_line_type  line;
  logic            scl_rise;
  logic            scl_fall;
  logic            start_seen;
  logic            stop_seen;
  logic [7:0]      data;
  smbbt_state_type state;
  smbbt_mode_type  mode;
  logic            master;
  logic            byte_event;
  logic            start_request;
  logic            stop_request;
  logic            ack_response_needed;
  logic            arbitration_lost_flag;
  logic            ack;
  logic            start_flag;
  logic            data_written;
  logic            addr_phase;
  logic [3:0]      bit_cnt;
  logic [7:0]      tmr;
  logic            tick;
  logic            phase_hi;
  logic            drive_sda_low;
  logic            drive_scl_low;
  logic            ctrl_wr;
  logic            data_wr;
  logic            data_load;
  logic            shift_en;
  logic            ack_bit;
  logic            transmitting;
  logic            sda_tx_low;

  smbbt_sync u_sync
  (
    .clk        (clk),
    .nrst       (nrst),
    .pin_in     (pin_in),
    .line       (line),
    .scl_rise   (scl_rise),
    .scl_fall   (scl_fall),
    .start_seen (start_seen),
    .stop_seen  (stop_seen)
  );

  // Register decode
  assign ctrl_wr = sfr_req.wr && sfr_req.addr == `SMBBT_CTRL_ADDR;
  // Writes honoured only while flag set
  assign data_wr   = sfr_req.wr && sfr_req.addr == `SMBBT_DATA_ADDR && byte_event;
  assign data_load = data_wr;
  assign transmitting = mode == SMBBT_MST_TX || mode == SMBBT_SLV_TX;
  assign master = mode == SMBBT_MST_TX || mode == SMBBT_MST_RX;

  // Sample line on each rising clock edge of the eight data bits, not the acknowledge bit
  assign shift_en = state == SMBBT_BITS && scl_rise && !byte_event;

  smbbt_shift u_shift
  (
    .clk       (clk),
    .nrst      (nrst),
    .load      (data_load),
    .load_data (sfr_req.wdata),
    .shift     (shift_en),
    .sda_in    (line.sda),
    .data      (data)
  );

  // Half-bit timer for master clocking; restarts every half period
  always_ff @(posedge clk)
  begin
    if (!nrst || tmr == HALF_CYC - 8'h01)
      tmr <= 8'h00;
    else
      tmr <= tmr + 8'h01;
  end
  assign tick = tmr == HALF_CYC - 8'h01;

  // Master clock phase toggles each half bit
  always_ff @(posedge clk)
  begin
    if (!nrst)
      phase_hi <= 1'b0;
    else if (state == SMBBT_BITS || state == SMBBT_ACK || state == SMBBT_STOP)
    begin
      if (master && tick && !byte_event)
        phase_hi <= ~phase_hi;
    end
    else
      phase_hi <= 1'b0;
  end

  // Remember a data write since the last event
  always_ff @(posedge clk)
  begin
    if (!nrst)
      data_written <= 1'b0;
    else if (data_wr)
      data_written <= 1'b1;
    else if (state == SMBBT_BITS)
      data_written <= 1'b0;
  end

  // Main byte sequencer
  always_ff @(posedge clk)
  begin
    if (!nrst || !enable)
    begin
      state      <= SMBBT_IDLE;
      mode       <= SMBBT_SLV_RX;
      bit_cnt    <= 4'h0;
      addr_phase <= 1'b0;
      byte_event <= 1'b0;
      ack_response_needed   <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      ack        <= 1'b0;
      start_flag <= 1'b0;
    end
    else
    begin
      // Clearing the event by software; clears lost-arbitration too
      if (ctrl_wr && !sfr_req.wdata[`SMBBT_BIT_SI])
      begin
        byte_event <= 1'b0;
        arbitration_lost_flag <= 1'b0;
      end
      if (ctrl_wr)
      begin
        ack <= sfr_req.wdata[`SMBBT_BIT_ACK];
        if (!sfr_req.wdata[`SMBBT_BIT_STA])
          start_flag <= 1'b0;
      end
      if (start_seen && !master)
      begin
        state      <= SMBBT_BITS;
        bit_cnt    <= 4'h0;
        addr_phase <= 1'b1;
        mode       <= SMBBT_SLV_RX;
      end
      else if (stop_seen && !master && state != SMBBT_IDLE)
      begin
        state <= SMBBT_IDLE;
        mode  <= SMBBT_SLV_RX;
        if (state != SMBBT_MUTE && !addr_phase)
          byte_event <= 1'b1;
      end
      else
      begin
        case (state)
          SMBBT_IDLE:
          begin
            if (tick && start_request && line.scl && line.sda && !byte_event)
            begin
              state <= SMBBT_START;
              mode  <= SMBBT_MST_TX;
            end
          end
          SMBBT_START:
          begin
            if (tick)
            begin
              state      <= SMBBT_HOLD;
              byte_event <= 1'b1;
              start_flag <= 1'b1;
              addr_phase <= 1'b1;
            end
          end
          SMBBT_BITS:
          begin
            if (scl_rise && !byte_event)
            begin
              // Lost arbitration: slave receiver keeps observed byte
              if (transmitting && !drive_sda_low && !line.sda && master)
              begin
                arbitration_lost_flag <= 1'b1;
                mode  <= SMBBT_SLV_RX;
                byte_event <= 1'b1;
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (bit_cnt == 4'h8 && scl_fall)
            begin
              if (!transmitting)
              begin
                if (addr_phase && !master)
                begin
                  if (slave_inhibit || data[7:1] != OWN_ADDR)
                    state <= SMBBT_MUTE;
                  else
                  begin
                    byte_event <= 1'b1;
                    ack_response_needed <= 1'b1;
                    start_flag <= 1'b1;
                    state <= SMBBT_ACK;
                  end
                end
                else
                begin
                  // Ack response needed on each received byte
                  byte_event <= 1'b1;
                  ack_response_needed <= 1'b1;
                  state <= SMBBT_ACK;
                end
              end
              else
                state <= SMBBT_ACK;
            end
          end
          SMBBT_ACK:
          begin
            if (scl_fall && !byte_event)
            begin
              // Ack request cleared after ack cycle
              ack_response_needed <= 1'b0;
              bit_cnt <= 4'h0;
              if (transmitting)
              begin
                ack <= ~ack_bit;
                byte_event <= 1'b1;
                state <= SMBBT_HOLD;
              end
              else if (!ack && addr_phase && !master)
                state <= SMBBT_MUTE;
              else
              begin
                if (addr_phase && !master && data[0])
                  mode <= SMBBT_SLV_TX;
                state <= SMBBT_HOLD;
              end
              addr_phase <= 1'b0;
            end
          end
          SMBBT_HOLD:
          begin
            if (!byte_event && tick)
            begin
              if (stop_request && master)
                state <= SMBBT_STOP;
              else
              begin
                state <= SMBBT_BITS;
                if (addr_phase)
                  mode <= SMBBT_MST_TX;
                else if (master)
                  mode <= data_written ? SMBBT_MST_TX : SMBBT_MST_RX;
                else
                  mode <= data_written ? SMBBT_SLV_TX : SMBBT_SLV_RX;
              end
            end
          end
          SMBBT_STOP:
          begin
            if (tick && line.scl)
            begin
              state <= SMBBT_IDLE;
              mode  <= SMBBT_SLV_RX;
            end
          end
          SMBBT_MUTE:
            state <= SMBBT_MUTE;
          default:
            state <= SMBBT_IDLE;
        endcase
      end
    end
  end

  // Bit level moves only while clock is low; a change under high clock is a START or STOP
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sda_tx_low <= 1'b0;
    else if (!line.scl)
      sda_tx_low <= state == SMBBT_BITS && transmitting && !data[7] && bit_cnt < 4'h8;
  end

  // Requests from software; hardware clears stop once sent
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      start_request <= 1'b0;
      stop_request  <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        start_request <= sfr_req.wdata[`SMBBT_BIT_STA];
        stop_request  <= sfr_req.wdata[`SMBBT_BIT_STO];
      end
      else if (state == SMBBT_START && tick)
        start_request <= 1'b0;
      if (state == SMBBT_STOP && tick && line.scl)
        stop_request <= 1'b0;
    end
  end

  // Acknowledge level seen on the line
  assign ack_bit = line.sda;

  // Top bit drives the line, released for ones
  always_comb
  begin
    drive_sda_low = 1'b0;
    case (state)
      SMBBT_START: drive_sda_low = 1'b1;
      SMBBT_STOP:  drive_sda_low = !phase_hi || !line.scl || tmr < HALF_CYC / 8'h02;
      SMBBT_BITS:  drive_sda_low = sda_tx_low;
      SMBBT_ACK:   drive_sda_low = !transmitting && ack && !byte_event;
      default:     drive_sda_low = 1'b0;
    endcase
  end

  // Clock held low while event flag set
  assign drive_scl_low = byte_event || state == SMBBT_HOLD || (state == SMBBT_STOP && !phase_hi) ||
                         (master && (state == SMBBT_BITS || state == SMBBT_ACK) && !phase_hi);

  // Registered pin drivers; open-drain so output level is always low
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_oe  <= drive_scl_low;
      sda_oe  <= drive_sda_low;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Read data registered; data frozen while flag set
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sfr_rdata <= 8'h00;
    else if (sfr_req.rd && sfr_req.addr == `SMBBT_DATA_ADDR)
      sfr_rdata <= data;
    else if (sfr_req.rd && sfr_req.addr == `SMBBT_CTRL_ADDR)
      sfr_rdata <= {master, transmitting, start_flag, stop_request,
                    ack_response_needed, arbitration_lost_flag, ack, byte_event};
    else
      sfr_rdata <= 8'h00;
  end
endmodule

//--- testbench/smbbt_core_monitor.sv
// Port-level checks on the byte transfer block
`timescale 1ns/1ps
`include "smbbt_map.svh"
module smbbt_core_monitor
  import smbbt_pkg::*;
(
  input wire logic              clk,
  input wire logic              nrst,
  input wire smbbt_sfr_req_type sfr_req,
  input wire logic [7:0]        sfr_rdata,
  input wire logic              enable,
  input wire logic              slave_inhibit,
  input wire smbbt_line_type    pin_in,
  input wire logic              scl_out,
  input wire logic              scl_oe,
  input wire logic              sda_out,
  input wire logic              sda_oe
);
  logic       rd_any_q;
  logic       rd_ctrl_q;
  logic       rd_data_q;
  logic       ev_flag;
  logic       have_last;
  logic [7:0] last_data;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Which register the answer on the read bus belongs to
  always_ff @(posedge clk)
  begin
    rd_any_q <= nrst && sfr_req.rd;
    rd_ctrl_q <= nrst && sfr_req.rd && sfr_req.addr == `SMBBT_CTRL_ADDR;
    rd_data_q <= nrst && sfr_req.rd && sfr_req.addr == `SMBBT_DATA_ADDR;
  end
  // Event flag as last read back; only known set, never guessed
  always_ff @(posedge clk)
  begin
    if (!nrst || (sfr_req.wr && sfr_req.addr == `SMBBT_CTRL_ADDR))
      ev_flag <= 1'b0;
    else if (rd_ctrl_q)
      ev_flag <= sfr_rdata[`SMBBT_BIT_SI];
  end
  // Last data read while frozen; any write forgets it
  always_ff @(posedge clk)
  begin
    if (!nrst || sfr_req.wr || !ev_flag)
      have_last <= 1'b0;
    else if (rd_data_q)
      have_last <= 1'b1;
    if (rd_data_q)
      last_data <= sfr_rdata;
  end
  sequence s_low_hold;
    scl_oe [*8];
  endsequence
  sequence s_start_hold;
    (sda_oe && !scl_oe) [*8];
  endsequence
  a_event_scl_held: assert property (ev_flag |-> scl_oe)
    else $error("clock line released while event flag set");
  a_data_frozen: assert property (rd_data_q && ev_flag && have_last |-> sfr_rdata == last_data)
    else $error("data register changed while event flag set");
  a_rdata_quiet: assert property (!rd_any_q |-> sfr_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_scl_low_min: assert property ($rose(scl_oe) |=> s_low_hold)
    else $error("clock low phase too short");
  a_scl_high_min: assert property ($fell(scl_oe) |=> !scl_oe [*8])
    else $error("clock high phase too short");
  a_start_order: assert property ($rose(sda_oe) && pin_in.scl |=> s_start_hold ##[1:400] scl_oe)
    else $error("start not followed by clock low in time");
  a_open_drain_zero: assert property (!scl_out && !sda_out)
    else $error("open drain output driven high");
  a_disable_release: assert property ($fell(enable) |-> ##[1:4] (!scl_oe && !sda_oe))
    else $error("lines still pulled after disable");
endmodule
bind smbbt_core smbbt_core_monitor u_mon (.clk(clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
  .enable(enable), .slave_inhibit(slave_inhibit), .pin_in(pin_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe));

//--- testbench/smbbt_slave_model.sv
// Behavioural slave on the two-wire bus facing the block as master
`timescale 1ns/1ps
module smbbt_slave_model
#(
  parameter logic [6:0] SLV_ADDR = 7'h50,
  parameter logic [7:0] TX_BYTE  = 8'h96
)
(
  input  wire logic  scl,
  input  wire logic  sda,
  output logic       sda_oe,
  output logic [7:0] last_byte,
  output logic       last_ack,
  output logic       stop_seen
);
  int         bitn = 0;
  logic       sel = 1'b0;
  logic       addr_ph = 1'b0;
  logic       rd_mode = 1'b0;
  logic [7:0] sh = 8'h00;
  initial
  begin
    sda_oe = 1'b0;
    last_byte = 8'h00;
    last_ack = 1'b1;
    stop_seen = 1'b0;
  end
  // Start arms the address phase
  always @(negedge sda)
  begin
    if (scl)
    begin
      bitn = 0;
      addr_ph = 1'b1;
      rd_mode = 1'b0;
      stop_seen = 1'b0;
    end
  end
  // Stop ends the transfer and lets go
  always @(posedge sda)
  begin
    if (scl)
    begin
      stop_seen = 1'b1;
      sel = 1'b0;
    end
  end
  always @(posedge scl)
  begin
    if (bitn < 8)
      sh = {sh[6:0], sda};
    if (bitn == 7)
    begin
      last_byte = sh;
      if (addr_ph)
        sel = (sh[7:1] == SLV_ADDR);
    end
    if (bitn == 8)
    begin
      if (addr_ph)
        rd_mode = sh[0];
      else if (rd_mode)
      begin
        last_ack = !sda;
        sel = sel && !sda;
      end
      addr_ph = 1'b0;
    end
    bitn = (bitn == 8) ? 0 : bitn + 1;
  end
  // ack writes, send read data; held late so no false start
  always @(negedge scl)
  begin
    if (bitn == 8)
      sda_oe <= #100 sel && (addr_ph || !rd_mode);
    else
      sda_oe <= #100 sel && rd_mode && !TX_BYTE[7 - bitn];
  end
endmodule

//--- testbench/smbus_byte_transfer_modes_tb_top.sv
// Self-checking bench for the byte transfer block with a slave on the bus
`timescale 1ns/1ps
`include "smbbt_map.svh"
module smbus_byte_transfer_modes_tb_top
  import smbbt_pkg::*;
;
  localparam logic [7:0] TX_BYTE = 8'h96;
  // Rows: byte written, control status expected after its ACK
  localparam logic [7:0] ROWS [3][2] = '{'{8'h80, 8'hC3}, '{8'h01, 8'hC3}, '{8'h5A, 8'hC3}};
  logic              clk = 1'b0;
  logic              nrst;
  logic              enable;
  logic              slave_inhibit;
  smbbt_sfr_req_type sfr_req;
  logic [7:0]        sfr_rdata;
  logic              scl_out;
  logic              scl_oe;
  logic              sda_out;
  logic              sda_oe;
  logic              p_sda_oe;
  logic              last_ack;
  logic              stop_seen;
  logic [7:0]        last_byte;
  logic [7:0]        c;
  smbbt_line_type    pin;
  int                fail_count = 0;
  int                compares = 0;
  int                cycles = 0;
  // Pull-ups on both lines; anyone pulling wins
  assign pin = '{scl: !scl_oe, sda: !(sda_oe || p_sda_oe)};
  always #12.5 clk = ~clk;
  smbbt_core dut (.clk(clk), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .enable(enable),
    .slave_inhibit(slave_inhibit), .pin_in(pin), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
    .sda_oe(sda_oe));
  smbbt_slave_model #(.SLV_ADDR(7'h50), .TX_BYTE(TX_BYTE)) u_slave (.scl(pin.scl), .sda(pin.sda),
    .sda_oe(p_sda_oe), .last_byte(last_byte), .last_ack(last_ack), .stop_seen(stop_seen));
  task automatic final_report();
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk8(input string name, input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    sfr_req <= '0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    sfr_req <= '0;
    #1;
    d = sfr_rdata;
  endtask
  // Poll status until the event flag shows; the timeout catches a hang
  task automatic wait_event();
    int n;
    n = 0;
    c = 8'h00;
    while (c[`SMBBT_BIT_SI] !== 1'b1 && n < 6000)
    begin
      sfr_rd(`SMBBT_CTRL_ADDR, c);
      n++;
    end
  endtask
  task automatic wait_stop();
    int n;
    n = 0;
    c = 8'hFF;
    while ((stop_seen !== 1'b1 || c[7] !== 1'b0) && n < 3000)
    begin
      sfr_rd(`SMBBT_CTRL_ADDR, c);
      n++;
    end
    chk8("stop_on_wire", {7'h00, stop_seen}, 8'h01);
    chk8("master_left", c & 8'h80, 8'h00);
  endtask
  // Load a byte while flagged, release it, check wire, status and echo
  task automatic send(input logic [7:0] b, input logic [7:0] st, input string name);
    logic [7:0] d;
    sfr_wr(`SMBBT_DATA_ADDR, b);
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h00);
    wait_event();
    chk8({name, "_status"}, c, st);
    chk8({name, "_wire"}, last_byte, b);
    sfr_rd(`SMBBT_DATA_ADDR, d);
    chk8({name, "_echo"}, d, b);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fail_count++;
      final_report();
    end
  end
  initial
  begin
    nrst = 1'b0;
    enable = 1'b1;
    slave_inhibit = 1'b1;
    sfr_req = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    sfr_rd(`SMBBT_DATA_ADDR, c);
    chk8("data_reset", c, `SMBBT_DATA_RESET);
    sfr_rd(`SMBBT_CTRL_ADDR, c);
    chk8("ctrl_reset", c, 8'h00);
    // Master write: start, address with write bit, then table rows
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h20);
    wait_event();
    chk8("start_status", c & 8'hFD, 8'hE1);
    send(8'hA0, 8'hC3, "addr_wr");
    foreach (ROWS[i])
      send(ROWS[i][0], ROWS[i][1], "row");
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h10);
    wait_stop();
    // Data write with the flag clear must be ignored
    sfr_wr(`SMBBT_DATA_ADDR, 8'h33);
    sfr_rd(`SMBBT_DATA_ADDR, c);
    chk8("data_refused", c, 8'h5A);
    // Master read: address with read bit, then no data write
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h20);
    wait_event();
    send(8'hA1, 8'hC3, "addr_rd");
    sfr_rd(`SMBBT_DATA_ADDR, c);
    chk8("data_frozen", c, 8'hA1);
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h00);
    wait_event();
    chk8("mrx_status", c & 8'hFD, 8'h89);
    sfr_rd(`SMBBT_DATA_ADDR, c);
    chk8("mrx_data", c, TX_BYTE);
    chk8("scl_held", {7'h00, pin.scl}, 8'h00);
    // NACK the final byte and stop
    sfr_wr(`SMBBT_CTRL_ADDR, 8'h10);
    wait_stop();
    chk8("nack_sent", {7'h00, last_ack}, 8'h00);
    @(posedge clk);
    enable <= 1'b0;
    repeat (6) @(posedge clk);
    final_report();
  end
endmodule
